// ---- bmp_ctrl.sv ----
// Overview of operation
// - Burst entry needs low feedback, count 7, 24ms.
// - Paused burst resumes above burst-on level.
// - Burst turn-on comes from fixed 52kHz timer.
// - Burst pulse ends on current trip or 50%.
// - Burst-off level pauses switching until burst-on.
// - Above leave level, exit burst, full current.
// - Leaving burst forces up/down counter to 1.
// - Supply fault resets logic, switch held off.
// - Undervoltage charges supply, restarts with soft-start.
// - Supply overvoltage for 10us restarts, normal only.
// - Overload held 30ms restarts; not in burst.
// - Off-time output overvoltage for 100us latches.
// - Latch cleared only by supply power-down.
// - Over-temperature restarts; ignored in burst.
// - On-time short winding for 190ns latches, normal only.
// - Latched, startup cell cycles 10.5V to 18V.
// - Gate forced off after maximum on-time.
// - Foldback excess current lowers current limit.
// - Up/down counter steps once per 48ms, 1..7.
`default_nettype none
module bmp_ctrl import bmp_pkg::*; #(
  parameter int       BEB_N   = BEB_CYC,
  parameter int       OLP_N   = OLP_CYC,
  parameter int       UDC_N   = UDC_CYC,
  parameter int       ZCOVP_N = ZCOVP_CYC,
  parameter int       MAXON_N = MAXON_CYC,
  parameter logic [7:0] FOLD_T = FOLD_THR
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire bmp_cmp_s         cmp_raw,
  input  wire logic             on_req,
  input  wire logic             off_req,
  input  wire logic [CSL_W-1:0] izc_code,
  output var  logic             gate,
  output var  logic             startup_en,
  output var  logic             burst_mode,
  output var  logic             soft_start,
  output var  logic             latched,
  output var  logic             auto_restart,
  output var  logic [2:0]       ud_count,
  output var  logic [CSL_W-1:0] cs_limit
);
  localparam int BW = $clog2(BURST_PER_CYC);
  localparam int OW = $clog2(MAXON_N + 1);
  localparam int UW = $clog2(UDC_N);
  localparam logic [BW-1:0] B_LAST = BW'(BURST_PER_CYC - 1);
  localparam logic [BW-1:0] B_ON   = BW'(BURST_ON_CYC);
  localparam logic [OW-1:0] O_LAST = OW'(MAXON_N - 1);
  localparam logic [UW-1:0] U_LAST = UW'(UDC_N - 1);

  logic [CMP_W-1:0] cmp_q;
  bmp_cmp_s         c;
  bmp_state_e       state;
  bmp_state_e       next_state;
  logic             beb_done;
  logic             olp_done;
  logic             ovp_done;
  logic             zcovp_done;
  logic             cssw_done;
  logic             in_burst;
  logic             leave;
  logic             run_ok;
  logic             maxon_hit;
  logic [BW-1:0]    bper;
  logic [OW-1:0]    on_cnt;
  logic [UW-1:0]    ucnt;
  logic             tick;
  logic             seen_zl;
  logic             seen_zh;
  logic             su_latch;
  logic [CSL_W-1:0] excess;

  // ==========================================================
  // Comparator inputs
  // ==========================================================
  // flag synchronisation
  bmp_sync #(.W(CMP_W)) u_sync (
    .clk (mclk),
    .rst (rst),
    .d   (cmp_raw),
    .q   (cmp_q)
  );
  assign c        = bmp_cmp_s'(cmp_q);
  assign in_burst = (state == ST_B_IDLE) || (state == ST_B_RUN);

  // ==========================================================
  // Persistence timers
  // ==========================================================
  // entry blanking
  bmp_timer #(.N(BEB_N)) u_beb (
    .clk  (mclk),
    .rst  (rst),
    .act  (c.fb_low && ud_count == ABM_COUNT && state == ST_NORMAL),
    .done (beb_done)
  );
  bmp_timer #(.N(OLP_N)) u_olp (
    .clk  (mclk),
    .rst  (rst),
    .act  (c.fb_leave && state == ST_NORMAL),
    .done (olp_done)
  );
  bmp_timer #(.N(OVP_CYC)) u_ovp (
    .clk  (mclk),
    .rst  (rst),
    .act  (c.vcc_ov && state == ST_NORMAL),
    .done (ovp_done)
  );
  bmp_timer #(.N(ZCOVP_N)) u_zcovp (
    .clk  (mclk),
    .rst  (rst),
    .act  (c.zc_ovp && !gate && (state == ST_NORMAL || in_burst)),
    .done (zcovp_done)
  );
  bmp_timer #(.N(CSSW_CYC)) u_cssw (
    .clk  (mclk),
    .rst  (rst),
    .act  (c.cs_sw && gate && state == ST_NORMAL),
    .done (cssw_done)
  );

  // ==========================================================
  // Mode sequencing
  // ==========================================================
  // Latch events outrank undervoltage so a fault is never forgotten.
  always_comb begin
    next_state = state;
    unique case (state)
      ST_CHARGE: begin
        if (c.vcc_on) begin
          next_state = ST_NORMAL;
        end
      end
      ST_NORMAL: begin
        if (zcovp_done || cssw_done) begin
          next_state = ST_LATCH;
        end else if (c.vcc_uv) begin
          next_state = ST_CHARGE;
        end else if (ovp_done || olp_done || c.otp) begin
          next_state = ST_AUTORST;
        end else if (beb_done) begin
          next_state = ST_B_IDLE;
        end
      end
      ST_B_IDLE: begin
        if (zcovp_done) begin
          next_state = ST_LATCH;
        end else if (c.vcc_uv) begin
          next_state = ST_CHARGE;
        end else if (c.fb_leave) begin
          next_state = ST_NORMAL;
        end else if (c.fb_bon) begin
          next_state = ST_B_RUN;
        end
      end
      ST_B_RUN: begin
        if (zcovp_done) begin
          next_state = ST_LATCH;
        end else if (c.vcc_uv) begin
          next_state = ST_CHARGE;
        end else if (c.fb_leave) begin
          next_state = ST_NORMAL;
        end else if (c.fb_boff) begin
          next_state = ST_B_IDLE;
        end
      end
      ST_AUTORST: begin
        if (c.vcc_uv) begin
          next_state = ST_CHARGE;
        end
      end
      ST_LATCH: begin
        if (c.vcc_pd) begin
          next_state = ST_CHARGE;
        end
      end
      default: next_state = ST_CHARGE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_CHARGE;
    end else begin
      state <= next_state;
    end
  end

  assign leave = in_burst && next_state == ST_NORMAL;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soft_start   <= 1'b0;
      burst_mode   <= 1'b0;
      latched      <= 1'b0;
      auto_restart <= 1'b0;
    end else begin
      soft_start   <= state == ST_CHARGE && next_state == ST_NORMAL;
      burst_mode   <= next_state == ST_B_IDLE || next_state == ST_B_RUN;
      latched      <= next_state == ST_LATCH;
      auto_restart <= next_state == ST_AUTORST;
    end
  end

  // ==========================================================
  // Startup cell
  // ==========================================================
  // latched recharge cycling
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      su_latch <= 1'b0;
    end else if (state != ST_LATCH) begin
      su_latch <= 1'b0;
    end else if (c.vcc_uv) begin
      su_latch <= 1'b1;
    end else if (c.vcc_on) begin
      su_latch <= 1'b0;
    end
  end
  assign startup_en = (state == ST_CHARGE) || su_latch;

  // ==========================================================
  // Gate drive
  // ==========================================================
  assign run_ok = (state == ST_NORMAL && next_state == ST_NORMAL)
               || (state == ST_B_RUN && next_state == ST_B_RUN);
  assign maxon_hit = gate && on_cnt == O_LAST;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bper <= '0;
    end else if (state != ST_B_RUN || bper == B_LAST) begin
      bper <= '0;
    end else begin
      bper <= bper + BW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      on_cnt <= '0;
    end else if (!gate) begin
      on_cnt <= '0;
    end else begin
      on_cnt <= on_cnt + OW'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate <= 1'b0;
    end else if (!run_ok) begin
      gate <= 1'b0;
    end else if (maxon_hit) begin
      gate <= 1'b0;
    end else if (state == ST_B_RUN) begin
      if (gate && (c.cs_burst || bper >= B_ON)) begin
        gate <= 1'b0;
      end else if (bper == '0) begin
        gate <= 1'b1;
      end
    end else if (gate && off_req) begin
      gate <= 1'b0;
    end else if (!gate && on_req) begin
      gate <= 1'b1;
    end
  end

  // ==========================================================
  // Up/down counter
  // ==========================================================
  assign tick = ucnt == U_LAST;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ucnt    <= '0;
      seen_zl <= 1'b0;
      seen_zh <= 1'b0;
    end else if (tick) begin
      ucnt    <= '0;
      seen_zl <= c.fb_zl;
      seen_zh <= c.fb_zh;
    end else begin
      ucnt    <= ucnt + UW'(1);
      seen_zl <= seen_zl || c.fb_zl;
      seen_zh <= seen_zh || c.fb_zh;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ud_count <= UDC_MIN;
    end else if (state == ST_CHARGE || leave || c.fb_r1) begin
      ud_count <= UDC_MIN;
    end else if (tick && state == ST_NORMAL) begin
      if (!seen_zl && !c.fb_zl) begin
        if (ud_count != UDC_MAX) begin
          ud_count <= ud_count + 3'h1;
        end
      end else if (seen_zh || c.fb_zh) begin
        if (ud_count != UDC_MIN) begin
          ud_count <= ud_count - 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // Current limit
  // ==========================================================
  assign excess = izc_code > FOLD_T ? izc_code - FOLD_T : '0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_limit <= CSL_FULL;
    end else if (next_state == ST_B_IDLE || next_state == ST_B_RUN) begin
      cs_limit <= CSL_BURST;
    end else begin
      cs_limit <= CSL_FULL - excess;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence stop_s;
    state == ST_B_IDLE ##1 !gate;
  endsequence
  sequence charge_s;
    state == ST_CHARGE ##0 startup_en ##1 !gate;
  endsequence

  burst_entry_a: assert property ($rose(burst_mode) |->
    $past(beb_done) && $past(ud_count) == ABM_COUNT)
    else $error("burst entered without all conditions");
  burst_resume_a: assert property (state == ST_B_IDLE &&
    c.fb_bon && !c.fb_leave && !c.vcc_uv && !zcovp_done
    |=> state == ST_B_RUN ##1 gate)
    else $error("burst did not resume switching");
  burst_freq_a: assert property ($rose(gate) &&
    state == ST_B_RUN |-> bper == BW'(1))
    else $error("burst turn-on not on timer");
  burst_duty_a: assert property (gate &&
    state == ST_B_RUN |-> bper <= B_ON)
    else $error("burst duty above limit");
  burst_stop_a: assert property (state == ST_B_RUN &&
    c.fb_boff && !c.fb_leave && !c.vcc_uv && !zcovp_done
    |=> stop_s)
    else $error("burst did not pause");
  leave_count_a: assert property (leave |=>
    ud_count == UDC_MIN && state == ST_NORMAL)
    else $error("counter not reset on leaving burst");
  uv_reset_a: assert property (state == ST_AUTORST &&
    c.vcc_uv |=> charge_s)
    else $error("undervoltage did not reset");
  latch_hold_a: assert property (state == ST_LATCH &&
    !c.vcc_pd |=> state == ST_LATCH && !gate)
    else $error("latch released without power-down");
  latch_cell_a: assert property (state == ST_LATCH &&
    next_state == ST_LATCH && c.vcc_uv |=> startup_en[*2])
    else $error("startup cell not enabled while latched");
  max_on_a: assert property (gate |-> on_cnt <= O_LAST)
    else $error("gate high beyond maximum on-time");
endmodule // bmp_ctrl
`default_nettype wire

// ---- bmp_pkg.sv ----
`default_nettype none
package bmp_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_PER_US     = CLK_HZ / 1_000_000;
  localparam int BEB_MS         = 24;
  localparam int BEB_CYC        = BEB_MS * (CLK_HZ / 1000);
  localparam int OLP_MS         = 30;
  localparam int OLP_CYC        = OLP_MS * (CLK_HZ / 1000);
  localparam int UDC_MS         = 48;
  localparam int UDC_CYC        = UDC_MS * (CLK_HZ / 1000);
  localparam int OVP_US         = 10;
  localparam int OVP_CYC        = OVP_US * CLK_PER_US;
  localparam int ZCOVP_US       = 100;
  localparam int ZCOVP_CYC      = ZCOVP_US * CLK_PER_US;
  localparam int CSSW_NS        = 190;
  localparam int CSSW_CYC       = (CSSW_NS * CLK_PER_US + 999) / 1000;
  localparam int BURST_HZ       = 52_000;
  localparam int BURST_PER_CYC  = CLK_HZ / BURST_HZ;
  localparam int BURST_DUTY_PCT = 50;
  localparam int BURST_ON_CYC   = BURST_PER_CYC * BURST_DUTY_PCT / 100;
  localparam int MAXON_US       = 20;
  localparam int MAXON_CYC      = MAXON_US * CLK_PER_US;
  // ==========================================================
  // Counter and current limit
  // ==========================================================
  localparam logic [2:0] UDC_MIN   = 3'h1;
  localparam logic [2:0] UDC_MAX   = 3'h7;
  localparam logic [2:0] ABM_COUNT = 3'h7;
  localparam int         CSL_W     = 8;
  localparam logic [7:0] CSL_FULL  = 8'hFF;
  localparam logic [7:0] CSL_BURST = 8'h57;
  localparam logic [7:0] FOLD_THR  = 8'h40;
  // ==========================================================
  // Comparator flags, each high when its condition holds
  // ==========================================================
  typedef struct packed {
    logic fb_low;
    logic fb_zl;
    logic fb_zh;
    logic fb_r1;
    logic fb_bon;
    logic fb_boff;
    logic fb_leave;
    logic cs_burst;
    logic cs_sw;
    logic zc_ovp;
    logic vcc_ov;
    logic vcc_uv;
    logic vcc_on;
    logic vcc_pd;
    logic otp;
  } bmp_cmp_s;
  localparam int CMP_W = $bits(bmp_cmp_s);
  typedef enum logic [5:0] {
    ST_CHARGE  = 6'h01,
    ST_NORMAL  = 6'h02,
    ST_B_IDLE  = 6'h04,
    ST_B_RUN   = 6'h08,
    ST_AUTORST = 6'h10,
    ST_LATCH   = 6'h20
  } bmp_state_e;
endpackage
`default_nettype wire

// ---- bmp_plant.sv ----
`default_nettype none
module bmp_plant import bmp_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       gate,
  input  wire logic       startup_en,
  input  wire logic       aux_on,
  input  wire logic       drain,
  input  wire logic [9:0] cs_ramp,
  input  wire bmp_cmp_s   flags,
  output var  bmp_cmp_s   cmp
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Supply capacitor, in tenths of a volt
  // ==========================================================
  localparam int UV_LVL = 105;
  localparam int ON_LVL = 180;
  localparam int PD_LVL = 60;
  // The charge is physical, so chip reset leaves it alone.
  int         vcc = 100;
  int         hi  = 0;
  logic [1:0] dv  = 2'h0;
  always @(posedge mclk) begin
    dv <= dv + 2'h1;
    hi <= gate ? hi + 1 : 0;
    if (drain)
      vcc <= (vcc > 4) ? vcc - 4 : 0;
    else if (startup_en)
      vcc <= vcc + 1;
    else if (!aux_on && dv == 2'h0)
      vcc <= vcc - 1;
  end
  // ==========================================================
  // Comparators
  // ==========================================================
  // Sense current ramps with on-time; a zero ramp never trips.
  always_comb begin
    cmp          = flags;
    cmp.vcc_uv   = vcc < UV_LVL;
    cmp.vcc_on   = vcc >= ON_LVL;
    cmp.vcc_pd   = vcc < PD_LVL;
    cmp.cs_burst = flags.cs_burst
                 | (gate && cs_ramp != 10'h0 && hi >= cs_ramp);
  end
endmodule // bmp_plant
`default_nettype wire

// ---- bmp_sync.sv ----
`default_nettype none
module bmp_sync import bmp_pkg::*; #(
  parameter int W = CMP_W
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // ==========================================================
  // Three stages; a change counts once stages two and three agree.
  // ==========================================================
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1[i] <= 1'b0;
          s2[i] <= 1'b0;
          s3[i] <= 1'b0;
          q[i]  <= 1'b0;
        end else begin
          s1[i] <= d[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            q[i] <= s3[i];
          end
        end
      end
    end
  endgenerate
endmodule // bmp_sync
`default_nettype wire

// ---- bmp_timer.sv ----
`default_nettype none
module bmp_timer #(
  parameter int N = 10
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic act,
  output var  logic done
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N);
  logic [CW-1:0] cnt;
  // ==========================================================
  // Persistence: any drop of act restarts the wait.
  // ==========================================================
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
    end else if (!act) begin
      cnt <= '0;
    end else if (cnt != LAST) begin
      cnt <= cnt + CW'(1);
    end
  end
  assign done = act && (cnt == LAST);
endmodule // bmp_timer
`default_nettype wire

// ---- burst_mode_protection_ctrl_test.sv ----
`default_nettype none
module burst_mode_protection_ctrl_test import bmp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BEB = 50;
  localparam int OLP = 60;
  localparam int UDC = 40;
  localparam int ZOV = 20;
  // Kept above the burst on-time so that burst pulses are not cut short.
  localparam int MXON = 600;
  logic             mclk, rst, on_req, off_req, aux_on, drain;
  logic             gate, startup_en, burst_mode, soft_start;
  logic             latched, auto_restart;
  logic [2:0]       ud_count;
  logic [CSL_W-1:0] izc_code, cs_limit;
  logic [9:0]       cs_ramp;
  bmp_cmp_s         fl, cmp;
  int bad_count = 0, n_checks = 0, cyc = 0, ghi = 0, su_r = 0;
  int seed, t0, n, len;
  logic su_p = 1'b0;
  bmp_ctrl #(.BEB_N(BEB), .OLP_N(OLP), .UDC_N(UDC), .ZCOVP_N(ZOV),
    .MAXON_N(MXON), .FOLD_T(FOLD_THR)) dut (.mclk(mclk), .rst(rst),
    .cmp_raw(cmp), .on_req(on_req), .off_req(off_req),
    .izc_code(izc_code), .gate(gate), .startup_en(startup_en),
    .burst_mode(burst_mode), .soft_start(soft_start),
    .latched(latched), .auto_restart(auto_restart),
    .ud_count(ud_count), .cs_limit(cs_limit));
  bmp_plant plant (.mclk(mclk), .gate(gate), .startup_en(startup_en),
    .aux_on(aux_on), .drain(drain), .cs_ramp(cs_ramp), .flags(fl),
    .cmp(cmp));
  // ==========================================================
  // Clock, watch counters and hang limit
  // ==========================================================
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (gate === 1'b1) ghi <= ghi + 1;
    if (startup_en === 1'b1 && su_p !== 1'b1) su_r <= su_r + 1;
    su_p <= startup_en;
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end
  // ==========================================================
  // Shared tasks
  // ==========================================================
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge mclk);
  endtask
  // A bounded wait; the check that follows reports a miss.
  task automatic await(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge mclk);
  endtask
  task automatic pulse(output int l);
    int t;
    await(gate, 1'b1, 2000);
    t = cyc;
    await(gate, 1'b0, 2000);
    l = cyc - t;
  endtask
  // Drop the winding supply, let the startup cell recharge.
  task automatic recharge();
    aux_on = 1'b0;
    await(startup_en, 1'b1, 1000);
    check("startup_en", startup_en, 1);
    check("gate", gate, 0);
    await(soft_start, 1'b1, 2000);
    check("soft_start", soft_start, 1);
    aux_on = 1'b1;
    tick(2);
    check("soft_start", soft_start, 0);
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    seed = 32'h1a57;
    fl = '0;
    {on_req, off_req, drain, aux_on} = 4'h1;
    izc_code = 8'h00;
    cs_ramp = 10'h000;
    rst = 1'b1;
    tick(5);
    check("gate", gate, 0);
    check("startup_en", startup_en, 1);
    check("ud_count", ud_count, 1);
    check("cs_limit", cs_limit, CSL_FULL);
    check("modes", {burst_mode, latched, auto_restart}, 0);
    rst = 1'b0;
    recharge();
    tick(9 * UDC);
    check("ud_count", ud_count, 7);
    fl.fb_zl = 1'b1;
    fl.fb_zh = 1'b1;
    tick(9 * UDC);
    check("ud_count", ud_count, 1);
    fl.fb_zh = 1'b0;
    tick(3 * UDC);
    check("ud_count", ud_count, 1);
    fl.fb_zl = 1'b0;
    tick(9 * UDC);
    check("ud_count", ud_count, 7);
    fl.fb_r1 = 1'b1;
    tick(6);
    check("ud_count", ud_count, 1);
    fl.fb_r1 = 1'b0;
    tick(9 * UDC);
    check("ud_count", ud_count, 7);
    for (n = 0; n < 6; n++) begin
      izc_code = 8'($random(seed));
      tick(3);
      check("cs_limit", cs_limit, izc_code > FOLD_THR ?
            CSL_FULL - (izc_code - FOLD_THR) : CSL_FULL);
    end
    izc_code = 8'h00;
    on_req = 1'b1;
    tick(1);
    on_req = 1'b0;
    tick(10);
    check("gate", gate, 1);
    off_req = 1'b1;
    tick(1);
    off_req = 1'b0;
    check("gate", gate, 0);
    on_req = 1'b1;
    tick(1);
    on_req = 1'b0;
    pulse(len);
    check("max_on", len >= MXON - 1 && len <= MXON + 1, 1);
    fl.fb_low = 1'b1;
    tick(BEB - 20);
    fl.fb_low = 1'b0;
    tick(40);
    check("burst_mode", burst_mode, 0);
    fl.fb_low = 1'b1;
    await(burst_mode, 1'b1, BEB + 20);
    check("burst_mode", burst_mode, 1);
    check("cs_limit", cs_limit, CSL_BURST);
    fl.fb_low = 1'b0;
    n = ghi;
    for (t0 = 0; t0 < 300; t0++) begin
      on_req = 1'($random(seed));
      tick(1);
    end
    check("idle_gate", ghi, n);
    on_req = 1'b1;
    fl.fb_bon = 1'b1;
    await(gate, 1'b1, 1000);
    t0 = cyc;
    await(gate, 1'b0, 1000);
    check("burst_on", cyc - t0, BURST_ON_CYC);
    await(gate, 1'b1, 1000);
    check("burst_per", cyc - t0, BURST_PER_CYC);
    cs_ramp = 10'd100;
    pulse(len);
    check("cs_trip", len >= 100 && len < BURST_ON_CYC, 1);
    {fl.otp, fl.vcc_ov, fl.cs_sw} = 3'h7;
    tick(700);
    check("auto_restart", auto_restart, 0);
    check("latched", latched, 0);
    {fl.otp, fl.vcc_ov, fl.cs_sw} = 3'h0;
    {fl.fb_bon, fl.fb_boff} = 2'h1;
    tick(1000);
    n = ghi;
    tick(1500);
    check("paused_gate", ghi, n);
    {fl.fb_bon, fl.fb_boff} = 2'h2;
    await(gate, 1'b1, 1000);
    check("gate", gate, 1);
    fl.fb_leave = 1'b1;
    await(burst_mode, 1'b0, 20);
    t0 = cyc;
    check("burst_mode", burst_mode, 0);
    check("ud_count", ud_count, 1);
    on_req = 1'b0;
    fl.fb_bon = 1'b0;
    tick(2);
    check("cs_limit", cs_limit, CSL_FULL);
    await(auto_restart, 1'b1, OLP + 20);
    check("olp_wait", cyc - t0 >= OLP, 1);
    fl.fb_leave = 1'b0;
    recharge();
    fl.vcc_ov = 1'b1;
    tick(300);
    fl.vcc_ov = 1'b0;
    tick(10);
    check("auto_restart", auto_restart, 0);
    fl.vcc_ov = 1'b1;
    await(auto_restart, 1'b1, 520);
    check("auto_restart", auto_restart, 1);
    fl.vcc_ov = 1'b0;
    recharge();
    fl.otp = 1'b1;
    tick(8);
    check("auto_restart", auto_restart, 1);
    fl.otp = 1'b0;
    recharge();
    on_req = 1'b1;
    tick(1);
    on_req = 1'b0;
    await(gate, 1'b1, 10);
    fl.cs_sw = 1'b1;
    await(latched, 1'b1, 25);
    check("latched", latched, 1);
    fl.cs_sw = 1'b0;
    n = ghi;
    for (t0 = 0; t0 < 200; t0++) begin
      on_req = 1'($random(seed));
      tick(1);
    end
    on_req = 1'b0;
    check("latched_gate", ghi, n);
    n = su_r;
    aux_on = 1'b0;
    tick(1500);
    check("startup_cycles", su_r - n >= 2, 1);
    check("latched", latched, 1);
    drain = 1'b1;
    await(latched, 1'b0, 200);
    check("latched", latched, 0);
    drain = 1'b0;
    recharge();
    fl.zc_ovp = 1'b1;
    tick(10);
    fl.zc_ovp = 1'b0;
    tick(10);
    check("latched", latched, 0);
    fl.zc_ovp = 1'b1;
    await(latched, 1'b1, ZOV + 20);
    check("latched", latched, 1);
    conclude();
  end
endmodule // burst_mode_protection_ctrl_test
`default_nettype wire
